// [core/file_reg_alu_branch_exec.sv]
// fetch/execute core for clear, invert, +1/-1 (with skip) and jump
// assumes a program memory on clk_sys answering fetch_addr in the
// same cycle, and a loader that preloads file registers on clk_sys
// Function
// RL1: clear writes 00h into the addressed register and sets the zero flag.
// RL2: destination bit 0 sends the result to the accumulator, 1 to the file.
// RL3: invert complements the register, goes to the destination, sets Z; the core updates Z from the result, set only when it is zero.
// RL4: minus one decrements the register, goes to destination, updates Z.
// RL5: plus one increments the register, goes to destination, updates Z.
// RL6: minus-one-skip writes the result and skips on zero, flags untouched.
// RL7: plus-one-skip writes the result and skips on zero, flags untouched.
// RL8: a skip discards the prefetched word and runs a no-op in its place.
// RL9: jump loads its 9-bit immediate into pc[8:0] and status[6:5] above.
// RL10: jump is unconditional, takes two cycles and leaves flags alone.
// RL11: a zero-flag update sets Z for a zero result and clears it otherwise.
`timescale 1ns/100ps
`default_nettype none
module file_reg_alu_branch_exec (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic [10:0] fetch_addr,
  input wire logic [11:0] fetch_data,
  input wire logic load_en,
  input wire logic [4:0] load_addr,
  input wire logic [7:0] load_data,
  input wire logic [4:0] peek_addr,
  output logic [7:0] peek_data,
  output logic [7:0] acc_value,
  output logic [7:0] status_value,
  output logic [11:0] exec_word,
  output logic flush_slot
);
  logic [7:0] rf [fre_pkg::REG_COUNT];
  logic [7:0] next_rf [fre_pkg::REG_COUNT];
  logic [10:0] pc;
  logic [10:0] next_pc;
  logic [11:0] ir;
  logic [11:0] next_ir;
  logic [7:0] acc;
  logic [7:0] next_acc;
  logic slot;
  logic next_slot;
  logic [7:0] peek;
  logic [7:0] next_peek;

  fre_pkg::op_e op;
  logic [4:0] ir_f;
  logic ir_d;
  logic [8:0] imm;
  logic [7:0] operand;
  logic [7:0] alu_result;
  logic alu_zero;
  logic writes_zero;
  logic skip_kind;
  logic file_op;
  logic write_file;
  logic write_acc;
  logic skip_req;
  logic jump;
  logic [7:0] status;

  // decode of the word now in execute
  always_comb begin
    op = fre_pkg::no_op;
    if ((ir & fre_pkg::CLEAR_MASK) == fre_pkg::CLEAR_CODE) begin
      op = fre_pkg::clear_file_reg_op;
    end else if ((ir & fre_pkg::JUMP_MASK) == fre_pkg::JUMP_CODE) begin
      op = fre_pkg::jump_immediate_op;
    end else begin
      case (ir & fre_pkg::FILE_OP_MASK)
        fre_pkg::INVERT_CODE: op = fre_pkg::invert_file_reg_op;
        fre_pkg::MINUS_CODE: op = fre_pkg::minus_one_op;
        fre_pkg::PLUS_CODE: op = fre_pkg::plus_one_op;
        fre_pkg::MINUS_SKIP_CODE: op = fre_pkg::minus_one_skip_zero_op;
        fre_pkg::PLUS_SKIP_CODE: op = fre_pkg::plus_one_skip_zero_op;
        default: op = fre_pkg::no_op;
      endcase
    end
  end

  assign ir_f = ir[fre_pkg::FADDR_W-1:0];
  assign ir_d = ir[fre_pkg::DEST_BIT];
  assign imm = ir[fre_pkg::IMM_W-1:0];
  assign operand = rf[ir_f];
  assign status = rf[fre_pkg::STATUS_ADDR];

  exec_alu u_alu (
    .op(op),
    .operand(operand),
    .result(alu_result),
    .result_zero(alu_zero),
    .writes_zero(writes_zero),
    .skip_kind(skip_kind)
  );

  assign file_op = (op != fre_pkg::no_op) &&
                   (op != fre_pkg::jump_immediate_op);
  // clear has no destination bit; it always targets the file
  assign write_file = file_op && ((op == fre_pkg::clear_file_reg_op) ||
                      (ir_d == fre_pkg::DEST_FILE)); // RL1 RL2
  assign write_acc = file_op && (op != fre_pkg::clear_file_reg_op) &&
                     (ir_d == fre_pkg::DEST_ACC); // RL2
  assign skip_req = skip_kind && alu_zero; // RL6 RL7
  assign jump = (op == fre_pkg::jump_immediate_op); // RL10

  // pipeline: prefetch at pc while ir executes
  always_comb begin
    next_pc = pc + fre_pkg::PC_STEP;
    next_ir = fetch_data;
    next_slot = 1'b0;
    next_acc = acc;
    if (jump) begin
      next_pc = {status[fre_pkg::PAGE_HI:fre_pkg::PAGE_LO], imm}; // RL9
    end
    // the word fetched alongside a jump or a taken skip is dropped
    if (jump || skip_req) begin
      next_ir = fre_pkg::NOP_WORD; // RL8 RL10
      next_slot = 1'b1;
    end
    if (write_acc) begin
      next_acc = alu_result; // RL2
    end
    next_peek = rf[peek_addr];
  end

  // one next-value block per file entry; the loader wins over execute
  for (genvar i = 0; i < fre_pkg::REG_COUNT; i++) begin : g_file
    always_comb begin
      next_rf[i] = rf[i];
      if (load_en && (load_addr == 5'(i))) begin
        next_rf[i] = load_data;
      end else begin
        if (write_file && (ir_f == 5'(i))) begin
          next_rf[i] = alu_result; // RL2
        end
        // flag update is applied after a result aimed at status itself
        if ((5'(i) == fre_pkg::STATUS_ADDR) && writes_zero) begin
          next_rf[i][fre_pkg::Z_BIT] = alu_zero; // RL1 RL11
        end
      end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        if (5'(i) == fre_pkg::STATUS_ADDR) begin
          rf[i] <= fre_pkg::STATUS_RESET;
        end else begin
          rf[i] <= fre_pkg::FILE_RESET;
        end
      end else begin
        rf[i] <= next_rf[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pc <= fre_pkg::RESET_PC;
      ir <= fre_pkg::NOP_WORD;
      acc <= fre_pkg::ACC_RESET;
      slot <= 1'b0;
      peek <= fre_pkg::FILE_RESET;
    end else begin
      pc <= next_pc;
      ir <= next_ir;
      acc <= next_acc;
      slot <= next_slot;
      peek <= next_peek;
    end
  end

  assign fetch_addr = pc;
  assign acc_value = acc;
  assign status_value = status;
  assign exec_word = ir;
  assign flush_slot = slot;
  assign peek_data = peek;

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic quiet;
  assign quiet = !load_en;

  // clearing status itself leaves Z set on top of 00h, so it is left out
  a_clear_result: assert property ( // RL1
    (op == fre_pkg::clear_file_reg_op) && quiet &&
    (ir_f != fre_pkg::STATUS_ADDR)
    |=> (rf[$past(ir_f)] == fre_pkg::CLEAR_VALUE) &&
        status[fre_pkg::Z_BIT])
    else $error("clear did not zero the register or set Z");

  a_dest_acc: assert property ( // RL2
    write_acc && quiet && (ir_f != fre_pkg::STATUS_ADDR)
    |=> (acc == $past(alu_result)) && (rf[$past(ir_f)] == $past(operand)))
    else $error("accumulator destination not honoured");

  a_dest_file: assert property ( // RL2
    write_file && quiet && (ir_f != fre_pkg::STATUS_ADDR)
    |=> (rf[$past(ir_f)] == $past(alu_result)) && $stable(acc))
    else $error("file destination not honoured");

  // judged on the raw word and the landed value, so decode slips show up
  a_invert_value: assert property ( // RL3
    ((ir & fre_pkg::FILE_OP_MASK) == fre_pkg::INVERT_CODE) && quiet &&
    (ir_f != fre_pkg::STATUS_ADDR)
    |=> ($past(ir_d) ? rf[$past(ir_f)] : acc) == ~$past(operand))
    else $error("invert result wrong");

  a_minus_value: assert property ( // RL4
    ((ir & fre_pkg::FILE_OP_MASK) == fre_pkg::MINUS_CODE) && quiet &&
    (ir_f != fre_pkg::STATUS_ADDR)
    |=> ($past(ir_d) ? rf[$past(ir_f)] : acc) == $past(operand) - 8'h01)
    else $error("minus one result wrong");

  a_plus_value: assert property ( // RL5
    ((ir & fre_pkg::FILE_OP_MASK) == fre_pkg::PLUS_CODE) && quiet &&
    (ir_f != fre_pkg::STATUS_ADDR)
    |=> ($past(ir_d) ? rf[$past(ir_f)] : acc) == $past(operand) + 8'h01)
    else $error("plus one result wrong");

  a_skip_flags: assert property ( // RL6 RL7
    skip_kind && quiet &&
    !(write_file && (ir_f == fre_pkg::STATUS_ADDR))
    |=> $stable(status))
    else $error("skip variant changed status");

  a_skip_flush: assert property ( // RL8
    skip_kind && alu_zero
    |=> (ir == fre_pkg::NOP_WORD) && flush_slot &&
        (pc == $past(pc) + 11'h001))
    else $error("taken skip did not flush the prefetched word");

  a_skip_none: assert property ( // RL8
    skip_kind && !alu_zero |=> !flush_slot && (ir == $past(fetch_data)))
    else $error("untaken skip dropped a word");

  a_jump_target: assert property ( // RL9
    jump |=> pc == {$past(status[6:5]), $past(ir[8:0])})
    else $error("jump target wrong");

  a_jump_two: assert property ( // RL10
    jump && quiet
    |=> (op == fre_pkg::no_op) && $stable(status) && $stable(acc)
        ##1 !flush_slot)
    else $error("jump not a two-cycle flag-neutral branch");

  a_zero_flag: assert property ( // RL11
    writes_zero && quiet
    |=> status[fre_pkg::Z_BIT] == ($past(alu_result) == 8'h00))
    else $error("zero flag does not follow the result");

  c_clear: cover property (op == fre_pkg::clear_file_reg_op);
  c_skip_taken: cover property (skip_kind && alu_zero);
  c_jump_paged: cover property (jump && (status[6:5] != 2'b00));
  c_inc_wrap: cover property ((op == fre_pkg::plus_one_op) && alu_zero);
endmodule : file_reg_alu_branch_exec
`default_nettype wire

// [core/fre_pkg.sv]
// constants, encodings and the operation type for the file-register core
// assumes a 12-bit instruction word and a 32-entry, 8-bit register file
package fre_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 11;
  localparam int INSTR_W = 12;
  localparam int FADDR_W = 5;
  localparam int IMM_W = 9;
  localparam int REG_COUNT = 32;
  localparam int Z_BIT = 2;
  localparam int PAGE_LO = 5;
  localparam int PAGE_HI = 6;
  localparam int DEST_BIT = 5;

  localparam logic [7:0] CLEAR_VALUE = 8'h00;
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [4:0] STATUS_ADDR = 5'h03;
  localparam logic [10:0] RESET_PC = 11'h000;
  localparam logic [10:0] PC_STEP = 11'h001;

  localparam logic [11:0] NOP_WORD = 12'h000;
  localparam logic [11:0] FILE_OP_MASK = 12'hFC0;
  localparam logic [11:0] CLEAR_MASK = 12'hFE0;
  localparam logic [11:0] CLEAR_CODE = 12'h060;
  localparam logic [11:0] INVERT_CODE = 12'h240;
  localparam logic [11:0] MINUS_CODE = 12'h0C0;
  localparam logic [11:0] PLUS_CODE = 12'h280;
  localparam logic [11:0] MINUS_SKIP_CODE = 12'h2C0;
  localparam logic [11:0] PLUS_SKIP_CODE = 12'h3C0;
  localparam logic [11:0] JUMP_MASK = 12'hE00;
  localparam logic [11:0] JUMP_CODE = 12'hA00;

  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [2:0] {
    no_op,
    clear_file_reg_op,
    invert_file_reg_op,
    minus_one_op,
    plus_one_op,
    minus_one_skip_zero_op,
    plus_one_skip_zero_op,
    jump_immediate_op
  } op_e;
endpackage : fre_pkg

// [core/exec_alu.sv]
// single-operand arithmetic unit for the file-register core
// purely combinational; the caller registers its results
`timescale 1ns/100ps
`default_nettype none
module exec_alu (
  input wire fre_pkg::op_e op,
  input wire logic [7:0] operand,
  output logic [7:0] result,
  output logic result_zero,
  output logic writes_zero,
  output logic skip_kind
);
  always_comb begin
    case (op)
      fre_pkg::clear_file_reg_op: result = fre_pkg::CLEAR_VALUE; // RL1
      fre_pkg::invert_file_reg_op: result = ~operand; // RL3
      fre_pkg::minus_one_op,
      fre_pkg::minus_one_skip_zero_op: begin
        result = operand - fre_pkg::ONE; // RL4
      end
      fre_pkg::plus_one_op,
      fre_pkg::plus_one_skip_zero_op: begin
        result = operand + fre_pkg::ONE; // RL5
      end
      default: result = operand;
    endcase
  end

  // clear yields zero too, so the flag is set unconditionally for it
  assign result_zero = (result == fre_pkg::CLEAR_VALUE); // RL11

  // skip variants leave every flag alone
  assign writes_zero = (op == fre_pkg::clear_file_reg_op) ||
                       (op == fre_pkg::invert_file_reg_op) ||
                       (op == fre_pkg::minus_one_op) ||
                       (op == fre_pkg::plus_one_op); // RL6 RL7
  assign skip_kind = (op == fre_pkg::minus_one_skip_zero_op) ||
                     (op == fre_pkg::plus_one_skip_zero_op);
endmodule : exec_alu
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the file-register execution core
// assumes the bench is program memory, loader and peek user of the core
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [10:0] fetch_addr;
  logic [11:0] fetch_data;
  logic load_en = 1'b0;
  logic [4:0] load_addr = 5'h00;
  logic [7:0] load_data = 8'h00;
  logic [4:0] peek_addr = 5'h00;
  logic [7:0] peek_data;
  logic [7:0] acc_value;
  logic [7:0] status_value;
  logic [11:0] exec_word;
  logic flush_slot;
  logic [11:0] prog [0:2047];
  int fail_count = 0;
  int checks = 0;
  int flushes = 0;

  always #25 clk_sys = ~clk_sys;
  // memory answers in the same cycle, as the core expects
  assign fetch_data = prog[fetch_addr];
  // counted mid-cycle, away from the edge that launches the flag
  always @(negedge clk_sys) begin
    if (flush_slot === 1'b1) begin
      flushes++;
    end
  end

  file_reg_alu_branch_exec dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .fetch_addr(fetch_addr),
    .fetch_data(fetch_data),
    .load_en(load_en),
    .load_addr(load_addr),
    .load_data(load_data),
    .peek_addr(peek_addr),
    .peek_data(peek_data),
    .acc_value(acc_value),
    .status_value(status_value),
    .exec_word(exec_word),
    .flush_slot(flush_slot)
  );

  task automatic cmp8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8

  task automatic cmp_count(input string what, input int exp, input int got);
    checks++;
    if (got != exp) begin
      fail_count++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmp_count

  // core held in reset while the program is rewritten, so no stray word runs
  task automatic halt();
    @(negedge clk_sys);
    rst_n = 1'b0;
    for (int i = 0; i < 2048; i++) begin
      prog[i] = fre_pkg::NOP_WORD;
    end
  endtask : halt

  // program starts at address 4, after two preload edges
  task automatic go(input logic [4:0] a0, input logic [7:0] v0,
                    input logic [4:0] a1, input logic [7:0] v1);
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    flushes = 0;
    load_en = 1'b1;
    load_addr = a0;
    load_data = v0;
    @(negedge clk_sys);
    load_addr = a1;
    load_data = v1;
    @(negedge clk_sys);
    load_en = 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask : go

  task automatic peek(input logic [4:0] a, input logic [7:0] exp,
                      input string what);
    peek_addr = a;
    @(negedge clk_sys);
    cmp8(what, exp, peek_data);
  endtask : peek

  task automatic t_reset();
    halt();
    @(negedge clk_sys);
    cmp8("acc", 8'h00, acc_value);
    cmp8("word lo", 8'h00, exec_word[7:0]);
    cmp8("word hi", 8'h00, {4'h0, exec_word[11:8]});
    cmp8("pc lo", 8'h00, fetch_addr[7:0]);
    cmp8("pc hi", 8'h00, {5'h00, fetch_addr[10:8]});
    cmp8("flush", 8'h00, {7'h00, flush_slot});
  endtask : t_reset

  task automatic t_clear();
    halt();
    prog[4] = fre_pkg::CLEAR_CODE | 12'h008;
    go(5'h08, 8'h5A, 5'h03, 8'h00);
    cmp8("status", 8'h04, status_value);
    cmp8("acc", 8'h00, acc_value);
    peek(5'h08, 8'h00, "file");
  endtask : t_clear

  task automatic t_file_ops();
    logic [11:0] code [6] = '{fre_pkg::INVERT_CODE, fre_pkg::INVERT_CODE,
      fre_pkg::MINUS_CODE, fre_pkg::MINUS_CODE, fre_pkg::PLUS_CODE,
      fre_pkg::PLUS_CODE};
    logic [7:0] arg [6] = '{8'hFF, 8'h0F, 8'h01, 8'h00, 8'hFF, 8'h7F};
    logic [7:0] res [6] = '{8'h00, 8'hF0, 8'h00, 8'hFF, 8'h00, 8'h80};
    logic z;
    for (int i = 0; i < 6; i++) begin
      for (int d = 0; d < 2; d++) begin
        z = (res[i] == 8'h00);
        halt();
        prog[4] = code[i] | {6'h00, d[0], 5'h09};
        // zero flag preset to the opposite of what the result should give
        go(5'h09, arg[i], 5'h03, z ? 8'h00 : 8'h04);
        cmp8("status", {5'h00, z, 2'h0}, status_value);
        cmp8("acc", d[0] ? 8'h00 : res[i], acc_value);
        peek(5'h09, d[0] ? res[i] : arg[i], "file");
      end
    end
  endtask : t_file_ops

  task automatic t_skip();
    logic [11:0] code [4] = '{fre_pkg::MINUS_SKIP_CODE,
      fre_pkg::PLUS_SKIP_CODE, fre_pkg::MINUS_SKIP_CODE,
      fre_pkg::PLUS_SKIP_CODE};
    logic dst [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic [7:0] arg [4] = '{8'h01, 8'hFF, 8'h05, 8'h7F};
    logic [7:0] res [4] = '{8'h00, 8'h00, 8'h04, 8'h80};
    int skip;
    for (int i = 0; i < 4; i++) begin
      skip = (res[i] == 8'h00) ? 1 : 0;
      halt();
      prog[4] = code[i] | {6'h00, dst[i], 5'h0A};
      prog[5] = fre_pkg::PLUS_CODE | 12'h02B;
      go(5'h0A, arg[i], 5'h0B, 8'h20);
      cmp8("status", 8'h00, status_value);
      cmp8("acc", dst[i] ? 8'h00 : res[i], acc_value);
      cmp_count("flush", skip, flushes);
      peek(5'h0A, dst[i] ? res[i] : arg[i], "file");
      peek(5'h0B, skip == 1 ? 8'h20 : 8'h21, "next");
    end
  endtask : t_skip

  task automatic t_jump();
    logic [7:0] page [2] = '{8'h60, 8'h40};
    logic [8:0] k [2] = '{9'h1FF, 9'h000};
    logic [10:0] tgt;
    for (int i = 0; i < 2; i++) begin
      halt();
      tgt = {page[i][6:5], k[i]};
      prog[4] = fre_pkg::JUMP_CODE | {3'h0, k[i]};
      prog[5] = fre_pkg::PLUS_CODE | 12'h02C;
      prog[tgt] = fre_pkg::PLUS_CODE | 12'h02D;
      go(5'h03, page[i], 5'h03, page[i]);
      cmp8("status", page[i], status_value);
      cmp_count("flush", 1, flushes);
      peek(5'h0C, 8'h00, "skipped");
      peek(5'h0D, 8'h01, "target");
    end
  endtask : t_jump

  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    for (int i = 0; i < 2048; i++) begin
      prog[i] = 12'h000;
    end
    repeat (20) @(negedge clk_sys);
    t_reset();
    t_clear();
    t_file_ops();
    t_skip();
    t_jump();
    end_of_test();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
